// file: rtl/vic_defs.vh
`ifndef VIC_DEFS_VH
`define VIC_DEFS_VH
// register addresses in data memory space
`define VIC_ADDR_W        12
`define VIC_ADDR_PRIO     12'hfb2
// priority select fields
`define VIC_PRIO_GATE     3
`define VIC_PRIO_SEL_ALL  3'h7
`define VIC_PRIO_NONE     3'h0
`define VIC_PRIO_RST      4'h0
// edge mode fields
`define VIC_MODE_EDGE0    0
`define VIC_MODE_BYPASS   2
`define VIC_MODE_SCLK     3
`define VIC_MODE_RST      4'h0
// nesting status codes
`define VIC_NEST_IDLE     2'h0
`define VIC_NEST_ONE      2'h1
`define VIC_NEST_TWO      2'h2
`define VIC_NEST_BIT_LO   2
`define VIC_NEST_BIT_HI   3
// sample clock divider and filter depth
`define VIC_DIV_MAX       6'h3f
`define VIC_FILT_N        2
// request source indices (0 = shared vector)
`define VIC_NSRC          6
`define VIC_SRC_SHARED    0
`define VIC_SRC_EXTA      1
`define VIC_SRC_EXTB      2
`define VIC_SRC_SERIAL    3
`define VIC_SRC_TIMA      4
`define VIC_SRC_TIMB      5
`define VIC_FLAG_N        7
`define VIC_FLAG_BOTH     6
`endif

// file: rtl/vic_edge_detect.v
`include "vic_defs.vh"
// synchronised edge detector with optional sampled noise filter
module vic_edge_detect (
   // clock and reset
   input  wire       clock,
   input  wire       srst,
   // pin and mode
   input  wire       pin,
   input  wire       falling,
   input  wire       both,
   input  wire       filt_en,
   input  wire       sample_tick,
   // one-cycle edge event
   output reg        edge_pulse
);
   reg sync1_r;
   reg sync2_r;
   reg hist_r;
   reg lvl_r;
   reg prev_r;
   wire lvl_now;
   wire rise;
   wire fall;

   ////////////////////////////////////////////////////////////////////
   // two-stage synchroniser
   always @(posedge clock) begin
      if (srst) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
      end else begin
         sync1_r <= pin;
         sync2_r <= sync1_r;
      end
   end

   // filter: level changes only after two equal samples
   always @(posedge clock) begin
      if (srst) begin
         hist_r <= 1'b0;
         lvl_r  <= 1'b0;
      end else if (sample_tick) begin
         hist_r <= sync2_r;
         if (hist_r == sync2_r)
            lvl_r <= sync2_r;
      end
   end

   assign lvl_now = filt_en ? lvl_r : sync2_r;
   assign rise    = lvl_now & ~prev_r;
   assign fall    = ~lvl_now & prev_r;

   // edge event for one clock
   always @(posedge clock) begin
      if (srst) begin
         prev_r     <= 1'b0;
         edge_pulse <= 1'b0;
      end else begin
         prev_r     <= lvl_now;
         edge_pulse <= both ? (rise | fall) : (falling ? fall : rise);
      end
   end
endmodule // vic_edge_detect

// file: rtl/vic_ctrl.v
`include "vic_defs.vh"
module vic_ctrl (
   // clock and reset
   input  wire        clock,
   input  wire        srst,
   // data memory write/read port
   input  wire        mem_wr4,
   input  wire        mem_wr1,
   input  wire [1:0]  mem_bit,
   input  wire        mem_bit_val,
   input  wire [11:0] mem_addr,
   input  wire [3:0]  mem_wdata,
   output wire [3:0]  prio_rdata,
   // interrupt control instructions
   input  wire        unmask_all_op,
   input  wire        mask_all_op,
   input  wire        return_from_irq_op,
   input  wire [1:0]  restored_nest,
   // mode register writes
   input  wire        ext_a_mode_wr,
   input  wire [3:0]  ext_a_mode_wdata,
   input  wire        ext_b_mode_wr,
   input  wire        ext_b_mode_wdata,
   // nesting flag writes (bit access ignores bank enable)
   input  wire        nest_wr,
   input  wire [1:0]  nest_wdata,
   input  wire        nest_bit_wr,
   input  wire        nest_bit_sel,
   input  wire        nest_bit_val,
   // sources
   input  wire        ext_irq_a,
   input  wire        ext_irq_b,
   input  wire        ext_both_edge_irq,
   input  wire        interval_timer_irq,
   input  wire        serial_done_irq,
   input  wire        timer_a_match_irq,
   input  wire        timer_b_match_irq,
   input  wire        osc_div_tick,
   // flags from software
   input  wire [6:0]  src_enable_flag,
   input  wire        flag_clr,
   input  wire [2:0]  flag_clr_idx,
   // sequencer handshake
   input  wire        op_end,
   output wire        irq_take,
   output reg  [2:0]  vector_num,
   output reg  [3:0]  vector_addr,
   output reg  [1:0]  stacked_nest,
   output wire        standby_release,
   // status
   output wire [3:0]  high_prio_sel,
   output wire [3:0]  ext_a_edge_mode,
   output wire        ext_b_edge_mode,
   output wire [1:0]  nest_level,
   output wire [6:0]  req_flag
);
   // registers
   reg  [3:0] prio_r;
   reg  [3:0] mode_a_r;
   reg        mode_b_r;
   reg  [1:0] nest_r;
   reg  [6:0] flag_r;
   reg  [6:0] flag_nxt;
   reg  [5:0] div_r;
   // request path
   wire [2:0] hp_sel;
   wire       gate_open;
   wire [5:0] vreq;
   wire [5:0] elig;
   wire       tick;
   // edge events
   wire       ev_a;
   wire       ev_b;
   wire       ev_both;
   // winner of this cycle
   reg  [2:0] win;
   reg        any;

   // lowest source number wins
   function [2:0] first_set;
      input [5:0] v;
      integer k;
      begin
         first_set = 3'h0;
         for (k = `VIC_NSRC - 1; k >= 0; k = k - 1)
            if (v[k])
               first_set = k[2:0] + 3'h1;
      end
   endfunction

   // address decode of the priority select register
   function prio_hit;
      input [`VIC_ADDR_W-1:0] a;
      begin
         prio_hit = (a == `VIC_ADDR_PRIO);
      end
   endfunction

   // nesting level after an acceptance, never past two
   function [1:0] nest_step;
      input [1:0] s;
      begin
         nest_step = (s == `VIC_NEST_IDLE) ? `VIC_NEST_ONE : `VIC_NEST_TWO;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////
   // priority select register
   always @(posedge clock) begin
      if (srst)
         prio_r <= `VIC_PRIO_RST;
      else if (mem_wr4 && prio_hit(mem_addr))
         prio_r <= mem_wdata;
      else if (mem_wr1 && prio_hit(mem_addr))
         prio_r[mem_bit] <= mem_bit_val;
      else if (unmask_all_op)
         prio_r[`VIC_PRIO_GATE] <= 1'b1;
      else if (mask_all_op)
         prio_r[`VIC_PRIO_GATE] <= 1'b0;
   end

   // selected high source, 7 treated as none
   assign hp_sel = (prio_r[2:0] == `VIC_PRIO_SEL_ALL) ? `VIC_PRIO_NONE
                                                      : prio_r[2:0];
   // master gate bit
   assign gate_open = prio_r[`VIC_PRIO_GATE];

   ////////////////////////////////////////////////////////////////////
   // edge mode registers
   always @(posedge clock) begin
      if (srst) begin
         mode_a_r <= `VIC_MODE_RST;
         mode_b_r <= 1'b0;
      end else begin
         if (ext_a_mode_wr)
            mode_a_r <= ext_a_mode_wdata;
         if (ext_b_mode_wr)
            mode_b_r <= ext_b_mode_wdata;
      end
   end

   // divide-by-64 sample tick, or every clock
   always @(posedge clock) begin
      if (srst)
         div_r <= 6'h00;
      else if (osc_div_tick)
         div_r <= (div_r == `VIC_DIV_MAX) ? 6'h00 : div_r + 6'h01;
   end
   assign tick = mode_a_r[`VIC_MODE_SCLK] ? (osc_div_tick && div_r == `VIC_DIV_MAX)
                                          : 1'b1;

   ////////////////////////////////////////////////////////////////////
   // edge detectors
   vic_edge_detect u_ext_a (
      .clock       (clock),
      .srst        (srst),
      .pin         (ext_irq_a),
      .falling     (mode_a_r[`VIC_MODE_EDGE0]),
      .both        (1'b0),
      .filt_en     (~mode_a_r[`VIC_MODE_BYPASS]),
      .sample_tick (tick),
      .edge_pulse  (ev_a)
   );
   vic_edge_detect u_ext_b (
      .clock       (clock),
      .srst        (srst),
      .pin         (ext_irq_b),
      .falling     (mode_b_r),
      .both        (1'b0),
      .filt_en     (1'b0),
      .sample_tick (1'b1),
      .edge_pulse  (ev_b)
   );
   vic_edge_detect u_ext_both (
      .clock       (clock),
      .srst        (srst),
      .pin         (ext_both_edge_irq),
      .falling     (1'b0),
      .both        (1'b1),
      .filt_en     (1'b0),
      .sample_tick (1'b1),
      .edge_pulse  (ev_both)
   );

   ////////////////////////////////////////////////////////////////////
   // vectored requests: index 0 shared vector, flags 0 and 6 ORed
   assign vreq[0] = (flag_r[0] & src_enable_flag[0]) |
                    (flag_r[`VIC_FLAG_BOTH] & src_enable_flag[`VIC_FLAG_BOTH]);
   assign vreq[`VIC_SRC_EXTA] = flag_r[`VIC_SRC_EXTA] & src_enable_flag[`VIC_SRC_EXTA];
   assign vreq[`VIC_SRC_EXTB] = flag_r[`VIC_SRC_EXTB] & src_enable_flag[`VIC_SRC_EXTB];
   assign vreq[`VIC_SRC_SERIAL] = flag_r[`VIC_SRC_SERIAL] & src_enable_flag[`VIC_SRC_SERIAL];
   assign vreq[`VIC_SRC_TIMA] = flag_r[`VIC_SRC_TIMA] & src_enable_flag[`VIC_SRC_TIMA];
   assign vreq[`VIC_SRC_TIMB] = flag_r[`VIC_SRC_TIMB] & src_enable_flag[`VIC_SRC_TIMB];
   assign standby_release = |vreq;

   // nest level filter per request
   genvar g;
   generate
      for (g = 0; g < `VIC_NSRC; g = g + 1) begin : g_elig
         assign elig[g] = vreq[g] &&
                          (nest_r == `VIC_NEST_IDLE ||
                           (nest_r == `VIC_NEST_ONE && hp_sel == g + 1));
      end
   endgenerate

   // choose winner by fixed order
   always @* begin
      win = first_set(elig);
      any = |elig && gate_open && op_end;
   end
   assign irq_take = any;

   ////////////////////////////////////////////////////////////////////
   // acceptance outputs registered
   always @(posedge clock) begin
      if (srst) begin
         vector_num   <= 3'h0;
         vector_addr  <= 4'h0;
         stacked_nest <= `VIC_NEST_IDLE;
      end else begin
         if (any) begin
            vector_num   <= win;
            vector_addr  <= {win, 1'b0};
            stacked_nest <= nest_r;
         end
      end
   end

   // nesting flags
   always @(posedge clock) begin
      if (srst)
         nest_r <= `VIC_NEST_IDLE;
      else if (any)
         nest_r <= nest_step(nest_r);
      else if (return_from_irq_op)
         nest_r <= restored_nest;
      else if (nest_wr)
         nest_r <= nest_wdata;
      else if (nest_bit_wr)
         nest_r[nest_bit_sel] <= nest_bit_val;
   end

   ////////////////////////////////////////////////////////////////////
   // request flags: set wins over clear
   always @* begin
      flag_nxt = flag_r;
      if (flag_clr)
         flag_nxt[flag_clr_idx] = 1'b0;
      if (any && win != 3'h1)
         flag_nxt[win - 3'h1] = 1'b0;
      if (any && win == 3'h1) begin
         if (!(src_enable_flag[0] && src_enable_flag[`VIC_FLAG_BOTH])) begin
            if (src_enable_flag[0])
               flag_nxt[0] = 1'b0;
            else
               flag_nxt[`VIC_FLAG_BOTH] = 1'b0;
         end
      end
      flag_nxt[0] = flag_nxt[0] | interval_timer_irq;
      flag_nxt[`VIC_SRC_EXTA] = flag_nxt[`VIC_SRC_EXTA] | ev_a;
      flag_nxt[`VIC_SRC_EXTB] = flag_nxt[`VIC_SRC_EXTB] | ev_b;
      flag_nxt[`VIC_SRC_SERIAL] = flag_nxt[`VIC_SRC_SERIAL] | serial_done_irq;
      flag_nxt[`VIC_SRC_TIMA] = flag_nxt[`VIC_SRC_TIMA] | timer_a_match_irq;
      flag_nxt[`VIC_SRC_TIMB] = flag_nxt[`VIC_SRC_TIMB] | timer_b_match_irq;
      flag_nxt[`VIC_FLAG_BOTH] = flag_nxt[`VIC_FLAG_BOTH] | ev_both;
   end

   always @(posedge clock) begin
      if (srst)
         flag_r <= 7'h00;
      else
         flag_r <= flag_nxt;
   end

   // status views
   assign prio_rdata      = prio_r;
   assign high_prio_sel   = prio_r;
   assign ext_a_edge_mode = mode_a_r;
   assign ext_b_edge_mode = mode_b_r;
   assign nest_level      = nest_r;
   assign req_flag        = flag_r;
endmodule // vic_ctrl

// file: sim/vic_seq_model.sv
module vic_seq_model (
   // clock and pacing
   input  wire logic clock,
   input  wire logic slow,
   // current operation ends
   output logic      op_end
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] cnt_r = 2'h0;
   initial op_end = 1'b0;
   // ends every cycle, or every fourth one when slow
   always @(posedge clock) begin
      cnt_r  <= cnt_r + 2'h1;
      op_end <= !slow || cnt_r == 2'h2;
   end
endmodule // vic_seq_model

// file: sim/vic_ctrl_chk.sv
module vic_ctrl_chk (
   // clock and reset
   input wire logic       clock,
   input wire logic       srst,
   // strobes and handshake
   input wire logic       mem_wr4,
   input wire logic       mem_wr1,
   input wire logic       unmask_all_op,
   input wire logic       op_end,
   input wire logic       irq_take,
   // state and vector
   input wire logic [3:0] high_prio_sel,
   input wire logic [1:0] nest_level,
   input wire logic [1:0] stacked_nest,
   input wire logic [2:0] vector_num,
   input wire logic [3:0] vector_addr
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);
   ////////////////////////////////////////////////////////////////////////////
   gate_blocks_a: assert property (irq_take |-> high_prio_sel[3])
      else $error("take with gate shut");
   op_end_wait_a: assert property (irq_take |-> op_end)
      else $error("take mid operation");
   nest_block_a: assert property (irq_take |-> !nest_level[1])
      else $error("take at level two");
   high_only_a: assert property (irq_take && nest_level == 2'h1
      |=> {1'b0, vector_num} == ($past(high_prio_sel) & 4'h7)) else $error("low nested");
   nest_adv_a: assert property (irq_take |=> nest_level == $past(nest_level) + 2'h1
      && stacked_nest == $past(nest_level)) else $error("nest step");
   vec_addr_a: assert property (irq_take |=> vector_addr == {vector_num, 1'b0})
      else $error("vector address");
   unmask_set_a: assert property (unmask_all_op && !mem_wr4 && !mem_wr1
      |=> high_prio_sel[3]) else $error("gate not set");
   reset_clear_a: assert property ($fell(srst) |-> !high_prio_sel && !nest_level)
      else $error("not cleared");
   // main scenarios
   cover property (irq_take && nest_level == 2'h1);
   cover property (irq_take && nest_level == 2'h0);
   cover property (irq_take && $past(op_end) == 1'b0);
endmodule // vic_ctrl_chk
bind vic_ctrl vic_ctrl_chk u_chk (.clock, .srst, .mem_wr4, .mem_wr1, .unmask_all_op, .op_end,
   .irq_take, .high_prio_sel, .nest_level, .stacked_nest, .vector_num, .vector_addr);

// file: sim/vic_ctrl_tb.sv
`define CK(a, b) begin \
   checks++; \
   if ((a) !== (b)) begin \
      err_count++; \
      $display("wrong value at %0t: %h vs %h", $time, a, b); \
   end \
end
module vic_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clock, srst, mem_wr4, mem_wr1, mem_bit_val, unmask_all_op, mask_all_op;
   logic        return_from_irq_op, ext_a_mode_wr, ext_b_mode_wr, ext_b_mode_wdata, nest_wr;
   logic        nest_bit_wr, nest_bit_sel, nest_bit_val, ext_irq_a, ext_irq_b, ext_both_edge_irq;
   logic        interval_timer_irq, serial_done_irq, timer_a_match_irq, timer_b_match_irq;
   logic        osc_div_tick, flag_clr, op_end, slow, irq_take, standby_release, ext_b_edge_mode;
   logic [1:0]  mem_bit, restored_nest, nest_wdata, stacked_nest, nest_level;
   logic [2:0]  flag_clr_idx, vector_num;
   logic [3:0]  mem_wdata, ext_a_mode_wdata, vector_addr, prio_rdata, high_prio_sel;
   logic [3:0]  ext_a_edge_mode;
   logic [6:0]  src_enable_flag, req_flag;
   logic [11:0] mem_addr;
   int          checks = 0;
   int          err_count = 0;
   int          takes = 0;
   int          taken = 0;
   vic_ctrl DUT (.clock, .srst, .mem_wr4, .mem_wr1, .mem_bit, .mem_bit_val, .mem_addr,
      .mem_wdata, .prio_rdata, .unmask_all_op, .mask_all_op, .return_from_irq_op,
      .restored_nest, .ext_a_mode_wr, .ext_a_mode_wdata, .ext_b_mode_wr, .ext_b_mode_wdata,
      .nest_wr, .nest_wdata, .nest_bit_wr, .nest_bit_sel, .nest_bit_val, .ext_irq_a,
      .ext_irq_b, .ext_both_edge_irq, .interval_timer_irq, .serial_done_irq,
      .timer_a_match_irq, .timer_b_match_irq, .osc_div_tick, .src_enable_flag, .flag_clr,
      .flag_clr_idx, .op_end, .irq_take, .vector_num, .vector_addr, .stacked_nest,
      .standby_release, .high_prio_sel, .ext_a_edge_mode, .ext_b_edge_mode, .nest_level,
      .req_flag);
   vic_seq_model u_seq (.clock, .slow, .op_end);
   ////////////////////////////////////////////////////////////////////////////
   // clock
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   // access tasks, all driven after the falling edge
   task automatic tick(input int n);
      repeat (n) @(negedge clock);
   endtask
   task automatic wr(input logic [11:0] a, input logic [3:0] d);
      {mem_wr4, mem_addr, mem_wdata} = {1'b1, a, d};
      tick(1);
      mem_wr4 = 1'b0;
      tick(4);
   endtask
   // count acceptances as the design sees them at the edge
   always @(posedge clock) begin
      if (irq_take === 1'b1)
         takes <= takes + 1;
   end
   task automatic gate(input logic on);
      {unmask_all_op, mask_all_op} = {on, !on};
      tick(1);
      {unmask_all_op, mask_all_op} = 2'h0;
      tick(1);
   endtask
   task automatic wb(input logic [11:0] a, input logic [1:0] b, input logic v);
      {mem_wr1, mem_addr, mem_bit, mem_bit_val} = {1'b1, a, b, v};
      tick(1);
      mem_wr1 = 1'b0;
      tick(1);
   endtask
   task automatic src(input logic [6:0] m);
      {timer_b_match_irq, timer_a_match_irq, serial_done_irq, interval_timer_irq} =
         {m[5], m[4], m[3], m[0]};
      tick(1);
      {timer_b_match_irq, timer_a_match_irq, serial_done_irq, interval_timer_irq} = 4'h0;
      tick(4);
   endtask
   task automatic clr(input logic [2:0] i);
      {flag_clr, flag_clr_idx} = {1'b1, i};
      tick(1);
      flag_clr = 1'b0;
      tick(1);
   endtask
   task automatic ret(input logic [1:0] r);
      {return_from_irq_op, restored_nest} = {1'b1, r};
      tick(1);
      return_from_irq_op = 1'b0;
      tick(1);
   endtask
   task automatic setn(input logic bw, input logic [1:0] d);
      {nest_wr, nest_bit_wr, nest_wdata, nest_bit_val} = {!bw, bw, d, d[1]};
      tick(1);
      {nest_wr, nest_bit_wr} = 2'h0;
      tick(1);
   endtask
   task automatic modes(input logic [3:0] a, input logic b);
      {ext_a_mode_wr, ext_b_mode_wr, ext_a_mode_wdata, ext_b_mode_wdata} = {2'h3, a, b};
      tick(1);
      {ext_a_mode_wr, ext_b_mode_wr} = 2'h0;
      tick(16);
      clr(3'h1);
      clr(3'h2);
   endtask
   task automatic pins(input logic [2:0] v);
      {ext_both_edge_irq, ext_irq_b, ext_irq_a} = v;
      tick(8);
   endtask
   task automatic take(input logic [2:0] n);
      int i;
      for (i = 0; i < 40 && takes == taken; i++)
         tick(1);
      if (takes == taken + 1) begin
         taken = takes;
         `CK(vector_num, n)
         `CK(vector_addr, {n, 1'b0})
      end else begin
         err_count++;
         conclude();
      end
   endtask
   task automatic conclude();
      $display("checks %0d, mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // main sequence
   initial begin
      {mem_wr4, mem_wr1, mem_bit, mem_bit_val, mem_addr, mem_wdata, unmask_all_op} = '0;
      {mask_all_op, return_from_irq_op, restored_nest, ext_a_mode_wr, ext_a_mode_wdata} = '0;
      {ext_b_mode_wr, ext_b_mode_wdata, nest_wr, nest_wdata, nest_bit_wr, nest_bit_val} = '0;
      {ext_irq_a, ext_irq_b, ext_both_edge_irq, interval_timer_irq, serial_done_irq} = '0;
      {timer_a_match_irq, timer_b_match_irq, osc_div_tick, flag_clr, flag_clr_idx, slow} = '0;
      {srst, nest_bit_sel, src_enable_flag} = {2'h3, 7'h7f};
      tick(8);
      srst = 1'b0;
      tick(2);
      `CK({high_prio_sel, nest_level}, 6'h00)
      `CK({ext_a_edge_mode, ext_b_edge_mode}, 5'h00)
      wr(12'hfb3, 4'h8);
      `CK(prio_rdata, 4'h0)
      src(7'h10);
      `CK({irq_take, req_flag, standby_release}, 9'h021)
      wr(12'hfb2, 4'h8);
      take(3'h5);
      `CK({req_flag, stacked_nest, nest_level}, 11'h001)
      slow = 1'b1;
      src(7'h20);
      `CK(req_flag, 7'h20)
      gate(1'b0);
      wr(12'hfb2, 4'hf);
      src(7'h00);
      `CK(req_flag, 7'h20)
      gate(1'b0);
      wr(12'hfb2, 4'he);
      `CK(prio_rdata, 4'he)
      take(3'h6);
      `CK({stacked_nest, nest_level}, 4'h6)
      src(7'h08);
      `CK(req_flag, 7'h08)
      ret(2'h1);
      `CK(nest_level, 2'h1)
      ret(2'h0);
      take(3'h4);
      // simultaneous requests and the shared vector
      ret(2'h0);
      gate(1'b0);
      src(7'h11);
      gate(1'b1);
      take(3'h1);
      `CK(req_flag, 7'h11)
      ret(2'h0);
      take(3'h1);
      clr(3'h0);
      ret(2'h0);
      take(3'h5);
      gate(1'b0);
      setn(1'b0, 2'h2);
      `CK(nest_level, 2'h2)
      setn(1'b1, 2'h0);
      `CK(nest_level, 2'h0)
      // single-bit access to the gate bit
      wb(12'hfb2, 2'h3, 1'b1);
      `CK(prio_rdata, 4'he)
      wb(12'hfb2, 2'h3, 1'b0);
      `CK(prio_rdata, 4'h6)
      // pin edges with the gate shut
      modes(4'h0, 1'b1);
      `CK(ext_b_edge_mode, 1'b1)
      pins(3'b010);
      pins(3'b100);
      `CK(req_flag, 7'h44)
      clr(3'h6);
      pins(3'b000);
      `CK(req_flag, 7'h44)
      clr(3'h6);
      clr(3'h2);
      ext_irq_a = 1'b1;
      tick(1);
      pins(3'b000);
      `CK(req_flag, 7'h00)
      pins(3'b001);
      `CK(req_flag, 7'h02)
      pins(3'b000);
      modes(4'h5, 1'b0);
      ext_irq_a = 1'b1;
      tick(1);
      pins(3'b000);
      `CK(req_flag, 7'h02)
      // divided sample clock: no samples until the oscillator ticks
      modes(4'h8, 1'b0);
      `CK(ext_a_edge_mode, 4'h8)
      pins(3'b001);
      `CK(req_flag, 7'h00)
      osc_div_tick = 1'b1;
      tick(100);
      `CK(req_flag, 7'h00)
      tick(40);
      `CK(req_flag, 7'h02)
      osc_div_tick = 1'b0;
      `CK(takes - taken, 0)
      conclude();
   end
endmodule // vic_ctrl_tb
